// [sli_panel_model.sv]
`timescale 1ns/1ps
module sli_panel_model (
	// Operator hands
	input wire logic holdCentral,
	input wire logic holdSound,
	// Push buttons
	output logic central_update_button,
	output logic sound_update_button
);
	// Plain contacts with no debounce, so a press reaches the block unchanged
	assign central_update_button = holdCentral;
	assign sound_update_button = holdSound;
endmodule

// [sli_pattern_gen.sv]
`timescale 1ns/1ps
module sli_pattern_gen (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic tick,
	// Pattern request
	input wire sli_pkg::sli_pattern_type pattern,
	// Lamp level
	output logic lampOn
);
	logic [sli_pkg::MS_W-1:0] ms_q;
	sli_pkg::sli_pattern_type prev_q;
	logic [sli_pkg::MS_W-1:0] period;

	// Restart the phase on a pattern change so each blinking pattern begins lit
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ms_q <= '0;
			prev_q <= sli_pkg::PAT_OFF;
		end else if (clkEn) begin
			prev_q <= pattern;
			if (pattern != prev_q || (tick && ms_q >= period - 1'b1)) begin
				ms_q <= '0;
			end else if (tick) begin
				ms_q <= ms_q + 1'b1;
			end
		end
	end

	always_comb begin
		unique case (pattern)
			sli_pkg::PAT_FAST: period = sli_pkg::MS_W'(2 * sli_pkg::FAST_HALF_MS);
			sli_pkg::PAT_SLOW: period = sli_pkg::MS_W'(sli_pkg::SLOW_PERIOD_MS);
			sli_pkg::PAT_DOUBLE: period = sli_pkg::MS_W'(sli_pkg::MULTI_PERIOD_MS);
			sli_pkg::PAT_TRIPLE: period = sli_pkg::MS_W'(sli_pkg::MULTI_PERIOD_MS);
			sli_pkg::PAT_SHUT: period = sli_pkg::MS_W'(sli_pkg::SHUT_PERIOD_MS);
			sli_pkg::PAT_FLICK: period = sli_pkg::MS_W'(2 * sli_pkg::FLICK_HALF_MS);
			sli_pkg::PAT_OFF: period = sli_pkg::MS_W'(2 * sli_pkg::BLINK_HALF_MS);
			sli_pkg::PAT_ON: period = sli_pkg::MS_W'(2 * sli_pkg::BLINK_HALF_MS);
		endcase
	end

	localparam int MP = sli_pkg::MULTI_ON_MS + sli_pkg::MULTI_GAP_MS;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			lampOn <= 1'b0;
		end else if (clkEn) begin
			unique case (pattern)
				sli_pkg::PAT_OFF: lampOn <= 1'b0;
				sli_pkg::PAT_ON: lampOn <= 1'b1;
				sli_pkg::PAT_FAST: lampOn <= ms_q < sli_pkg::MS_W'(sli_pkg::FAST_HALF_MS);
				sli_pkg::PAT_SLOW: lampOn <= ms_q < sli_pkg::MS_W'(sli_pkg::SLOW_ON_MS);
				sli_pkg::PAT_DOUBLE: lampOn <= (ms_q < sli_pkg::MS_W'(2 * MP))
					&& ((ms_q % sli_pkg::MS_W'(MP)) < sli_pkg::MS_W'(sli_pkg::MULTI_ON_MS));
				sli_pkg::PAT_TRIPLE: lampOn <= (ms_q < sli_pkg::MS_W'(3 * MP))
					&& ((ms_q % sli_pkg::MS_W'(MP)) < sli_pkg::MS_W'(sli_pkg::MULTI_ON_MS));
				sli_pkg::PAT_SHUT: lampOn <= ms_q < sli_pkg::MS_W'(sli_pkg::SHUT_ON_MS);
				sli_pkg::PAT_FLICK: lampOn <= ms_q < sli_pkg::MS_W'(sli_pkg::FLICK_HALF_MS);
			endcase
		end
	end
endmodule

// [sli_pkg.sv]
package sli_pkg;
	// ****************************************
	// Timing base
	// ****************************************
	localparam int CLK_HZ = 25000000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int TICK_W = 15;

	// ****************************************
	// Pattern timing in milliseconds
	// ****************************************
	localparam int FAST_HALF_MS = 100;
	localparam int SLOW_ON_MS = 200;
	localparam int SLOW_PERIOD_MS = 1500;
	localparam int MULTI_ON_MS = 150;
	localparam int MULTI_GAP_MS = 150;
	localparam int MULTI_PERIOD_MS = 2000;
	localparam int SHUT_ON_MS = 100;
	localparam int SHUT_PERIOD_MS = 5000;
	localparam int FLICK_HALF_MS = 40;
	localparam int BLINK_HALF_MS = 400;
	localparam int STICK_DARK_MS = 150;
	localparam int START_BLINK_MS = 1000;
	localparam int START_LIMIT_MS = 10000;
	localparam int MS_W = 14;

	// ****************************************
	// Lamp patterns
	// ****************************************
	typedef enum logic [2:0] {
		PAT_OFF, PAT_ON, PAT_FAST, PAT_SLOW, PAT_DOUBLE, PAT_TRIPLE, PAT_SHUT, PAT_FLICK
	} sli_pattern_type;
endpackage

// [sli_status_lamps.sv]
// Summary of operation
// - Central lamp steadily lit when ready and nothing else is shown.
// - Stick leaving centre darkens central lamp briefly, then lit again.
// - Central lamp blinks fast while scanning, no receiver or invalid signal.
// - Inter-unit link fault: central lamp short on, longer off.
// - Processor battery error: central lamp repeats double blink.
// - After undervoltage shutdown: one short blink every 5 seconds.
// - Sound lamp lit when ready, flickers while sound plays.
// - Sound lamp blinks rapidly on card, missing or corrupt sample set fault.
// - Sound lamp blinks ordinarily with no link to central unit.
// - Both lamps blink after power-on, steady within 10 seconds or error.
// - Central button held at power-on enters update mode, triple blink.
// - Sound button held at power-on enters update mode, triple blink.
`timescale 1ns/1ps
module sli_status_lamps #(
	parameter int TICK_CYCLES = sli_pkg::TICK_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clkEn,
	// Central unit conditions
	input wire logic centralReady,
	input wire logic stickMoved,
	input wire logic rxScanning,
	input wire logic rxMissing,
	input wire logic rxInvalid,
	input wire logic linkFault,
	input wire logic batteryError,
	input wire logic undervoltShutdown,
	// Sound unit conditions
	input wire logic soundReady,
	input wire logic soundPlaying,
	input wire logic cardFault,
	input wire logic soundNoLink,
	// Buttons
	input wire logic central_update_button,
	input wire logic sound_update_button,
	// Lamps and status
	output logic central_status_lamp,
	output logic sound_status_lamp,
	output logic centralUpdateMode,
	output logic soundUpdateMode,
	output logic startupError
);
	// ****************************************
	// Timebase
	// ****************************************
	logic tick;

	sli_tick #(
		.CYCLES(TICK_CYCLES)
	) u_tick (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.clkEn(clkEn),
		.tick(tick)
	);

	// ****************************************
	// Power-on sequencing
	// ****************************************
	// Buttons are caught after reset release, never inside the reset branch
	logic strapDone_q;
	logic [sli_pkg::MS_W-1:0] upMs_q;
	logic startBlink;
	logic limitHit;

	assign startBlink = upMs_q < sli_pkg::MS_W'(sli_pkg::START_BLINK_MS);
	assign limitHit = upMs_q >= sli_pkg::MS_W'(sli_pkg::START_LIMIT_MS);

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			strapDone_q <= 1'b0;
			centralUpdateMode <= 1'b0;
			soundUpdateMode <= 1'b0;
		end else if (clkEn && !strapDone_q) begin
			strapDone_q <= 1'b1;
			centralUpdateMode <= central_update_button;
			soundUpdateMode <= sound_update_button;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			upMs_q <= '0;
		end else if (clkEn && tick && !limitHit) begin
			upMs_q <= upMs_q + 1'b1;
		end
	end

	// Units not both ready by the limit flag an error; update mode is exempt
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			startupError <= 1'b0;
		end else if (clkEn && limitHit && !startupError) begin
			startupError <= !(centralUpdateMode || soundUpdateMode)
				&& !(centralReady && soundReady);
		end
	end

	// ****************************************
	// Stick dark pulse
	// ****************************************
	logic stickPrev_q;
	logic [sli_pkg::MS_W-1:0] darkMs_q;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			stickPrev_q <= 1'b0;
			darkMs_q <= '0;
		end else if (clkEn) begin
			stickPrev_q <= stickMoved;
			if (stickMoved && !stickPrev_q) begin
				darkMs_q <= sli_pkg::MS_W'(sli_pkg::STICK_DARK_MS);
			end else if (tick && darkMs_q != '0) begin
				darkMs_q <= darkMs_q - 1'b1;
			end
		end
	end

	// ****************************************
	// Pattern selection
	// ****************************************
	sli_pkg::sli_pattern_type centralPat;
	sli_pkg::sli_pattern_type soundPat;

	always_comb begin
		if (centralUpdateMode) begin
			centralPat = sli_pkg::PAT_TRIPLE;
		end else if (undervoltShutdown) begin
			centralPat = sli_pkg::PAT_SHUT;
		end else if (batteryError) begin
			centralPat = sli_pkg::PAT_DOUBLE;
		end else if (startBlink) begin
			centralPat = sli_pkg::PAT_FAST;
		end else if (linkFault) begin
			centralPat = sli_pkg::PAT_SLOW;
		end else if (rxScanning || rxMissing || rxInvalid) begin
			centralPat = sli_pkg::PAT_FAST;
		end else if (!centralReady) begin
			centralPat = sli_pkg::PAT_OFF;
		end else if (darkMs_q != '0) begin
			centralPat = sli_pkg::PAT_OFF;
		end else begin
			centralPat = sli_pkg::PAT_ON;
		end
	end

	always_comb begin
		if (soundUpdateMode) begin
			soundPat = sli_pkg::PAT_TRIPLE;
		end else if (startBlink) begin
			soundPat = sli_pkg::PAT_FAST;
		end else if (cardFault) begin
			soundPat = sli_pkg::PAT_FAST;
		end else if (soundNoLink) begin
			soundPat = sli_pkg::PAT_OFF;
		end else if (!soundReady) begin
			soundPat = sli_pkg::PAT_OFF;
		end else if (soundPlaying) begin
			soundPat = sli_pkg::PAT_FLICK;
		end else begin
			soundPat = sli_pkg::PAT_ON;
		end
	end

	// Ordinary blink for a lost link reuses the slow-period generator shape
	sli_pkg::sli_pattern_type soundSel;
	assign soundSel = (!soundUpdateMode && !startBlink && !cardFault && soundNoLink)
		? sli_pkg::PAT_SLOW : soundPat;

	// ****************************************
	// Lamp drivers
	// ****************************************
	sli_pattern_gen u_central (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.clkEn(clkEn),
		.tick(tick),
		.pattern(centralPat),
		.lampOn(central_status_lamp)
	);

	sli_pattern_gen u_sound (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.clkEn(clkEn),
		.tick(tick),
		.pattern(soundSel),
		.lampOn(sound_status_lamp)
	);
endmodule

// [sli_status_lamps_checker.sv]
`timescale 1ns/1ps
module sli_status_lamps_checker #(
	parameter int TICK_CYCLES = sli_pkg::TICK_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clkEn,
	// Conditions
	input wire logic batteryError,
	input wire logic undervoltShutdown,
	input wire logic central_update_button,
	input wire logic sound_update_button,
	// Outputs
	input wire logic central_status_lamp,
	input wire logic sound_status_lamp,
	input wire logic centralUpdateMode,
	input wire logic soundUpdateMode,
	input wire logic startupError
);
	localparam int LIMIT = sli_pkg::START_LIMIT_MS * TICK_CYCLES;
	int upCnt_q;
	// Saturates so a long run cannot wrap
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			upCnt_q <= 0;
		end else if (clkEn && upCnt_q < LIMIT) begin
			upCnt_q <= upCnt_q + 1;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	sequence litSoon_s(logic lamp);
		##[0:2] lamp;
	endsequence
	reset_dark_a: assert property (disable iff (1'h0) sys_rst |=> !central_status_lamp && !sound_status_lamp)
		else $error("lamp lit in reset");
	reset_modes_a: assert property (disable iff (1'h0) sys_rst |=> !centralUpdateMode && !soundUpdateMode && !startupError)
		else $error("status set in reset");
	central_latch_a: assert property ($fell(sys_rst) && clkEn |=> centralUpdateMode == $past(central_update_button))
		else $error("central update latch wrong");
	sound_latch_a: assert property ($fell(sys_rst) && clkEn |=> soundUpdateMode == $past(sound_update_button))
		else $error("sound update latch wrong");
	mode_hold_a: assert property (!$past(sys_rst) && !$past(sys_rst, 2) |-> $stable(centralUpdateMode) && $stable(soundUpdateMode))
		else $error("update mode changed");
	central_triple_a: assert property ($rose(centralUpdateMode) |-> litSoon_s(central_status_lamp))
		else $error("central triple not shown");
	sound_triple_a: assert property ($rose(soundUpdateMode) |-> litSoon_s(sound_status_lamp))
		else $error("sound triple not shown");
	shutdown_blink_a: assert property ($rose(undervoltShutdown) && clkEn && !centralUpdateMode |-> ##1 litSoon_s(central_status_lamp))
		else $error("shutdown blink missing");
	double_blink_a: assert property ($rose(batteryError) && clkEn && !undervoltShutdown && !centralUpdateMode
		|-> ##1 litSoon_s(central_status_lamp))
		else $error("double blink missing");
	frozen_lamps_a: assert property (!clkEn |=> $stable(central_status_lamp) && $stable(sound_status_lamp))
		else $error("lamp moved while frozen");
	startup_limit_a: assert property ($rose(startupError) |-> upCnt_q >= LIMIT - TICK_CYCLES)
		else $error("startup error too early");
endmodule
bind sli_status_lamps sli_status_lamps_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (.clk_sys(clk_sys),
	.sys_rst(sys_rst), .clkEn(clkEn),
	.batteryError(batteryError), .undervoltShutdown(undervoltShutdown),
	.central_update_button(central_update_button), .sound_update_button(sound_update_button),
	.central_status_lamp(central_status_lamp), .sound_status_lamp(sound_status_lamp),
	.centralUpdateMode(centralUpdateMode), .soundUpdateMode(soundUpdateMode), .startupError(startupError));

// [sli_tick.sv]
`timescale 1ns/1ps
module sli_tick #(
	parameter int CYCLES = sli_pkg::TICK_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clkEn,
	// Millisecond strobe
	output logic tick
);
	logic [sli_pkg::TICK_W-1:0] cnt_q;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cnt_q <= '0;
			tick <= 1'b0;
		end else if (clkEn) begin
			tick <= (cnt_q == sli_pkg::TICK_W'(CYCLES - 1));
			if (cnt_q == sli_pkg::TICK_W'(CYCLES - 1)) begin
				cnt_q <= '0;
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin mismatches++; $display("MISMATCH %0t %s", $time, msg); end end
module tb_top;
	logic clk_sys = 1'h0;
	logic sys_rst = 1'h1;
	logic clkEn = 1'h1;
	logic holdCentral = 1'h0;
	logic holdSound = 1'h0;
	logic [11:0] cond = 12'h000;
	logic cBtn, sBtn, cLamp, sLamp, cMode, sMode, startupError;
	int mismatches = 0;
	int comparisons = 0;
	initial begin
		forever #20 clk_sys = ~clk_sys;
	end
	sli_panel_model panel (.holdCentral(holdCentral), .holdSound(holdSound),
		.central_update_button(cBtn), .sound_update_button(sBtn));
	// Short tick so the millisecond patterns fit in a short run
	sli_status_lamps #(.TICK_CYCLES(4)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn),
		.centralReady(cond[0]), .stickMoved(cond[1]), .rxScanning(cond[2]), .rxMissing(cond[3]),
		.rxInvalid(cond[4]), .linkFault(cond[5]), .batteryError(cond[6]), .undervoltShutdown(cond[7]),
		.soundReady(cond[8]), .soundPlaying(cond[9]), .cardFault(cond[10]), .soundNoLink(cond[11]),
		.central_update_button(cBtn), .sound_update_button(sBtn),
		.central_status_lamp(cLamp), .sound_status_lamp(sLamp), .centralUpdateMode(cMode),
		.soundUpdateMode(sMode), .startupError(startupError));
	// ****************************************
	// Tasks
	// ****************************************
	task automatic cycles(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// Power-on with the buttons as given, 4 cycles of reset
	task automatic restart(input logic hc, input logic hs);
		sys_rst = 1'h1;
		cond = 12'h000;
		holdCentral = hc;
		holdSound = hs;
		cycles(4);
		`CHK({cLamp, sLamp, cMode, sMode, startupError}, 5'h00, "outputs in reset")
		sys_rst = 1'h0;
		cycles(2);
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		restart(1'h1, 1'h1);
		`CHK(cMode, 1'h1, "central update mode")
		`CHK(sMode, 1'h1, "sound update mode")
		cycles(2);
		`CHK(cLamp, 1'h1, "central triple")
		`CHK(sLamp, 1'h1, "sound triple")
		holdCentral = 1'h0;
		holdSound = 1'h0;
		cycles(20);
		`CHK({cMode, sMode}, 2'h3, "late release ignored")
		$display("update test done");
		restart(1'h0, 1'h0);
		`CHK({cMode, sMode}, 2'h0, "no update mode")
		cond[7] = 1'h1;
		cycles(4);
		`CHK(cLamp, 1'h1, "shutdown blink")
		$display("shutdown test done");
		restart(1'h0, 1'h0);
		cond[6] = 1'h1;
		cycles(4);
		`CHK(cLamp, 1'h1, "double blink")
		// Frozen state must survive a long pause
		clkEn = 1'h0;
		cycles(30);
		`CHK(cLamp, 1'h1, "frozen lamp")
		clkEn = 1'h1;
		cycles(2);
		`CHK(startupError, 1'h0, "no early startup error")
		$display("battery test done");
		restart(1'h0, 1'h0);
		cond = 12'h101;
		cycles(4100);
		`CHK({cLamp, sLamp}, 2'h3, "ready lamps steady")
		cond = 12'h103;
		cycles(2);
		`CHK(cLamp, 1'h0, "stick dark")
		cycles(700);
		`CHK(cLamp, 1'h1, "stick relit")
		cond = 12'h109;
		cycles(2);
		`CHK(cLamp, 1'h1, "fast blink lit")
		cycles(500);
		`CHK(cLamp, 1'h0, "fast blink dark")
		cond = 12'h121;
		cycles(2);
		`CHK(cLamp, 1'h1, "slow blink lit")
		cycles(1000);
		`CHK(cLamp, 1'h0, "slow blink dark")
		cond = 12'h149;
		cycles(502);
		`CHK(cLamp, 1'h1, "double over receiver")
		cond = 12'h501;
		cycles(2);
		`CHK(sLamp, 1'h1, "card blink lit")
		cycles(500);
		`CHK(sLamp, 1'h0, "card blink dark")
		cond = 12'h901;
		cycles(502);
		`CHK(sLamp, 1'h1, "no link not rapid")
		cycles(500);
		`CHK(sLamp, 1'h0, "no link blink dark")
		cond = 12'h301;
		cycles(2);
		`CHK(sLamp, 1'h1, "flicker lit")
		cycles(200);
		`CHK(sLamp, 1'h0, "flicker dark")
		$display("pattern test done");
		restart(1'h0, 1'h0);
		cycles(40100);
		`CHK(startupError, 1'h1, "startup error flagged")
		$display("startup test done");
		end_of_test();
	end
	// Whole run is about 49000 cycles
	initial begin
		#2500000;
		mismatches++;
		end_of_test();
	end
endmodule
